// ---- hw/bws_map.svh ----
// offsets, field positions and reset values of the bridge window registers
`ifndef BWS_MAP_SVH
`define BWS_MAP_SVH

// register byte offsets
`define BWS_OFS_IO 8'h1C
`define BWS_OFS_MEM 8'h20
`define BWS_OFS_PF 8'h24
`define BWS_OFS_PF_BASE_UP 8'h28
`define BWS_OFS_PF_TOP_UP 8'h2C
`define BWS_OFS_IO_UP 8'h30

// read-only capability values
`define BWS_IO_CAP 4'h1
`define BWS_PF_CAP 4'h1
`define BWS_CLAIM_TIMING 2'h1
`define BWS_66MHZ_CAP 1'h1
`define BWS_FAST_B2B 1'h0

// status field positions inside the 0x1C word
`define BWS_BIT_66MHZ 21
`define BWS_BIT_FB2B 23
`define BWS_BIT_PAR_MASTER 24
`define BWS_BIT_TIMING_LO 25
`define BWS_BIT_SIG_TABORT 27
`define BWS_BIT_RCV_TABORT 28
`define BWS_BIT_RCV_MABORT 29
`define BWS_BIT_RCV_SERR 30
`define BWS_BIT_DET_PERR 31

// window field positions
`define BWS_IO_BASE_LO 4
`define BWS_IO_TOP_LO 12
`define BWS_WIN_BASE_LO 4
`define BWS_WIN_TOP_LO 20

// reset values of writable fields
`define BWS_RST_NIBBLE 4'h0
`define BWS_RST_HALF 16'h0000
`define BWS_RST_WIN 12'h000
`define BWS_RST_WORD 32'h0000_0000

`endif

// ---- hw/bws_pkg.sv ----
// types of the bridge window and downstream status register bank
`default_nettype none
package bws_pkg;

   // sticky downstream error flags
   typedef struct packed {
      logic det_perr;
      logic rcv_serr;
      logic rcv_mabort;
      logic rcv_tabort;
      logic sig_tabort;
      logic par_master;
   } bws_flags_s;

   // all state of the bank
   typedef struct packed {
      logic [3:0] io_base;
      logic [3:0] io_top;
      logic [15:0] io_base_up;
      logic [15:0] io_top_up;
      bws_flags_s flags;
      logic [11:0] mem_base;
      logic [11:0] mem_top;
      logic [11:0] pf_base;
      logic [11:0] pf_top;
      logic [31:0] pf_base_up;
      logic [31:0] pf_top_up;
      logic [31:0] rdata;
      logic io_hit;
      logic mem_hit;
      logic pf_hit;
   } bws_state_s;

endpackage

`default_nettype wire

// ---- hw/bws_top.sv ----
// bridge address windows and downstream status register bank
//
// What this block does
// - io top nibble writable, low bits FFFh
// - io top reads capability nibble 1
// - io bits 31:16 from upper registers
// - io bottom low twelve bits zero
// - status bit 21 reads one
// - status bit 23 reads zero
// - bit 24 on parity error when enabled
// - claim timing field reads medium 01
// - bit 27 on target abort signalled
// - bit 28 on received target abort
// - bit 29 on received master abort
// - bit 30 on downstream system error
// - bit 31 on detected parity error
// - memory bottom bits 31:20 writable, low zero
// - memory top bits 31:20, low FFFFFh
// - memory window decides forwarding
// - prefetch capability nibble reads 0001
// - prefetch bottom bits 31:20 writable
// - prefetch top bits 31:20, decides forwarding
// - prefetch bottom bits 63:32 from upper
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bws_map.svh"

////////////////////////////////////////////////////////////////////////
// word layout seen by software
//
// 0x1C [3:0] io capability, [7:4] io bottom nibble,
//      [11:8] io capability, [15:12] io top nibble,
//      [31:16] downstream status half
// 0x20 [15:4] memory bottom, [31:20] memory top, low nibbles zero
// 0x24 prefetch bottom and top, capability in [3:0] and [19:16]
// 0x28 prefetch bottom bits 63:32
// 0x2C prefetch top bits 63:32
// 0x30 [15:0] io bottom bits 31:16, [31:16] io top bits 31:16
//
// other offsets read zero and ignore writes; there are no byte enables
//
// hazard: the status half shares its word with the io nibbles, so a
// write that clears a flag also rewrites both io nibbles
//
// the io and memory windows live in 32-bit space: a check address with
// any of bits 63:32 set can only hit the prefetch window

module bws_top
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // parity response enable from the command register
   input wire logic parity_resp_en,
   // downstream bus events, sampled each clock
   input wire logic downstream_parity_error_n,
   input wire logic downstream_system_error_n,
   input wire logic sig_target_abort,
   input wire logic rcv_target_abort,
   input wire logic rcv_master_abort,
   input wire logic det_parity_error,
   // transaction address to classify
   input wire logic [63:0] check_addr,
   // window matches, one cycle after check_addr
   output logic io_hit,
   output logic mem_hit,
   output logic pf_hit
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // inclusive window test; empty when bottom exceeds top
   function automatic logic in_window
   (
      input logic [63:0] addr,
      input logic [63:0] bottom,
      input logic [63:0] top
   );
      // two wide compares; the hit flops absorb their delay
      // an empty window needs no special case: both cannot pass
      // inclusive range compare
      in_window = (addr >= bottom) && (addr <= top);
   endfunction

   // register select, used by the write path only; the read path decodes with a case
   function automatic logic sel
   (
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      // exact byte match; no low address bit is a don't-care
      sel = (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   // current and next state
   bws_pkg::bws_state_s st;
   bws_pkg::bws_state_s next_st;

   // word views of the bank
   logic [31:0] io_word;
   logic [31:0] mem_word;
   logic [31:0] pf_word;
   logic [31:0] io_up_word;
   // decoded window bounds
   logic [63:0] io_bottom;
   logic [63:0] io_top;
   logic [63:0] mem_bottom;
   logic [63:0] mem_top;
   logic [63:0] pf_bottom;
   logic [63:0] pf_top;
   // flag set terms and write-one-clear terms
   bws_pkg::bws_flags_s flag_set;
   bws_pkg::bws_flags_s flag_clr;
   // write strobes per word
   logic wr_io;
   logic wr_mem;
   logic wr_pf;

   ////////////////////////////////////////////////////////////////////////
   // read views

   // io bottom byte, io top byte, downstream status half
   always_comb
   begin
      io_word = `BWS_RST_WORD;
      // reserved status bits keep the zero of this default
      // io bottom byte keeps its own capability nibble
      io_word[7:0] = {st.io_base, `BWS_IO_CAP};
      io_word[11:8] = `BWS_IO_CAP;
      io_word[15:12] = st.io_top;
      io_word[`BWS_BIT_66MHZ] = `BWS_66MHZ_CAP;
      io_word[`BWS_BIT_FB2B] = `BWS_FAST_B2B;
      io_word[`BWS_BIT_PAR_MASTER] = st.flags.par_master;
      io_word[`BWS_BIT_TIMING_LO +: 2] = `BWS_CLAIM_TIMING;
      io_word[`BWS_BIT_SIG_TABORT] = st.flags.sig_tabort;
      io_word[`BWS_BIT_RCV_TABORT] = st.flags.rcv_tabort;
      io_word[`BWS_BIT_RCV_MABORT] = st.flags.rcv_mabort;
      io_word[`BWS_BIT_RCV_SERR] = st.flags.rcv_serr;
      io_word[`BWS_BIT_DET_PERR] = st.flags.det_perr;
   end

   // memory and prefetch words, low nibbles fixed
   always_comb
   begin
      mem_word = `BWS_RST_WORD;
      mem_word[`BWS_WIN_BASE_LO +: 12] = st.mem_base;
      mem_word[`BWS_WIN_TOP_LO +: 12] = st.mem_top;
      pf_word = `BWS_RST_WORD;
      pf_word[3:0] = `BWS_PF_CAP;
      pf_word[19:16] = `BWS_PF_CAP;
      pf_word[`BWS_WIN_BASE_LO +: 12] = st.pf_base;
      pf_word[`BWS_WIN_TOP_LO +: 12] = st.pf_top;
      io_up_word = {st.io_top_up, st.io_base_up};
   end

   ////////////////////////////////////////////////////////////////////////
   // window bounds

   // bounds are wiring of the stored fields, so they move on the edge
   // that lands a write; a probe in that same cycle still sees the old ones
   // io window: 32-bit space, upper half from separate registers
   always_comb
   begin
      io_bottom = {32'h0000_0000, st.io_base_up, st.io_base, 12'h000};
      // io top low bits all ones
      io_top = {32'h0000_0000, st.io_top_up, st.io_top, 12'hFFF};
   end

   // memory window: 32-bit, 1 MB granules
   always_comb
   begin
      mem_bottom = {32'h0000_0000, st.mem_base, 20'h00000};
      mem_top = {32'h0000_0000, st.mem_top, 20'hFFFFF};
   end

   // prefetch window: 64-bit bounds
   always_comb
   begin
      pf_bottom = {st.pf_base_up, st.pf_base, 20'h00000};
      pf_top = {st.pf_top_up, st.pf_top, 20'hFFFFF};
   end

   ////////////////////////////////////////////////////////////////////////
   // status flag events

   // a source held active sets its flag every cycle, so a clear only
   // sticks once the source has let go
   // hardware set terms; inputs are already synchronous
   always_comb
   begin
      flag_set.par_master = !downstream_parity_error_n && parity_resp_en;
      flag_set.sig_tabort = sig_target_abort;
      flag_set.rcv_tabort = rcv_target_abort;
      flag_set.rcv_mabort = rcv_master_abort;
      flag_set.rcv_serr = !downstream_system_error_n;
      flag_set.det_perr = det_parity_error;
   end

   // write-one-clear terms from the status half
   // only a write to the shared word clears; reads never disturb a flag
   always_comb
   begin
      flag_clr.par_master = wr_io && reg_wdata[`BWS_BIT_PAR_MASTER];
      flag_clr.sig_tabort = wr_io && reg_wdata[`BWS_BIT_SIG_TABORT];
      flag_clr.rcv_tabort = wr_io && reg_wdata[`BWS_BIT_RCV_TABORT];
      flag_clr.rcv_mabort = wr_io && reg_wdata[`BWS_BIT_RCV_MABORT];
      flag_clr.rcv_serr = wr_io && reg_wdata[`BWS_BIT_RCV_SERR];
      flag_clr.det_perr = wr_io && reg_wdata[`BWS_BIT_DET_PERR];
   end

   ////////////////////////////////////////////////////////////////////////
   // write decode

   // one strobe per shared word
   // the three upper registers are decoded where they are stored
   always_comb
   begin
      wr_io = reg_wr && sel(reg_addr, `BWS_OFS_IO);
      wr_mem = reg_wr && sel(reg_addr, `BWS_OFS_MEM);
      wr_pf = reg_wr && sel(reg_addr, `BWS_OFS_PF);
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   // fills the whole next state; writes, flags, read data, matches
   always_comb
   begin
      next_st = st;
      // io word: only the two nibbles store, capability bits ignored
      if (wr_io)
      begin
         next_st.io_base = reg_wdata[`BWS_IO_BASE_LO +: 4];
         next_st.io_top = reg_wdata[`BWS_IO_TOP_LO +: 4];
      end
      next_st.flags = (st.flags & ~flag_clr) | flag_set;
      // memory window word
      if (wr_mem)
      begin
         next_st.mem_base = reg_wdata[`BWS_WIN_BASE_LO +: 12];
         next_st.mem_top = reg_wdata[`BWS_WIN_TOP_LO +: 12];
      end
      // prefetch window word
      if (wr_pf)
      begin
         next_st.pf_base = reg_wdata[`BWS_WIN_BASE_LO +: 12];
         next_st.pf_top = reg_wdata[`BWS_WIN_TOP_LO +: 12];
      end
      if (reg_wr && sel(reg_addr, `BWS_OFS_PF_BASE_UP))
      begin
         next_st.pf_base_up = reg_wdata;
      end
      // prefetch upper top
      if (reg_wr && sel(reg_addr, `BWS_OFS_PF_TOP_UP))
      begin
         next_st.pf_top_up = reg_wdata;
      end
      if (reg_wr && sel(reg_addr, `BWS_OFS_IO_UP))
      begin
         next_st.io_base_up = reg_wdata[15:0];
         next_st.io_top_up = reg_wdata[31:16];
      end
      // back to zero after one cycle, so a stale word never looks fresh
      // read data stands only in the cycle after the strobe
      next_st.rdata = `BWS_RST_WORD;
      if (reg_rd)
      begin
         case (reg_addr)
            `BWS_OFS_IO: next_st.rdata = io_word;
            `BWS_OFS_MEM: next_st.rdata = mem_word;
            `BWS_OFS_PF: next_st.rdata = pf_word;
            `BWS_OFS_PF_BASE_UP: next_st.rdata = st.pf_base_up;
            `BWS_OFS_PF_TOP_UP: next_st.rdata = st.pf_top_up;
            `BWS_OFS_IO_UP: next_st.rdata = io_up_word;
            // unmapped offsets read as zero
            default: next_st.rdata = `BWS_RST_WORD;
         endcase
      end
      // hits are registered: one cycle of latency buys a short path out
      // io space is 32-bit, so a high address never hits it
      next_st.io_hit = (check_addr[63:32] == 32'h0000_0000)
         && in_window(check_addr, io_bottom, io_top);
      next_st.mem_hit = (check_addr[63:32] == 32'h0000_0000)
         && in_window(check_addr, mem_bottom, mem_top);
      next_st.pf_hit = in_window(check_addr, pf_bottom, pf_top);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   // synchronous active-low reset to the power-on values
   // the bounds and word views follow from this state and need no reset
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st.io_base <= `BWS_RST_NIBBLE;
         st.io_top <= `BWS_RST_NIBBLE;
         st.io_base_up <= `BWS_RST_HALF;
         st.io_top_up <= `BWS_RST_HALF;
         st.flags <= '0;
         st.mem_base <= `BWS_RST_WIN;
         st.mem_top <= `BWS_RST_WIN;
         st.pf_base <= `BWS_RST_WIN;
         st.pf_top <= `BWS_RST_WIN;
         st.pf_base_up <= `BWS_RST_WORD;
         st.pf_top_up <= `BWS_RST_WORD;
         st.rdata <= `BWS_RST_WORD;
         st.io_hit <= 1'h0;
         st.mem_hit <= 1'h0;
         st.pf_hit <= 1'h0;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, straight from flops
   // plain copies of flops, so the forwarding logic sees no glitches

   assign reg_rdata = st.rdata;
   assign io_hit = st.io_hit;
   assign mem_hit = st.mem_hit;
   assign pf_hit = st.pf_hit;

endmodule // bws_top

`default_nettype wire

// ---- verification/bws_agent.sv ----
// downstream bus agent model raising one event per command
`timescale 1ns/1ns
`default_nettype none
module bws_agent
(
   // command from the bench
   input wire logic go,
   input wire logic [2:0] sel,
   // event lines toward the bank
   output wire logic downstream_parity_error_n,
   output wire logic downstream_system_error_n,
   output wire logic sig_target_abort,
   output wire logic rcv_target_abort,
   output wire logic rcv_master_abort,
   output wire logic det_parity_error
);
   // active-low lines rest high, as their pull-ups leave them
   assign downstream_parity_error_n = !(go && sel == 3'h0);
   assign downstream_system_error_n = !(go && sel == 3'h1);
   // abort and parity events, one per command
   assign sig_target_abort = go && sel == 3'h2;
   assign rcv_target_abort = go && sel == 3'h3;
   assign rcv_master_abort = go && sel == 3'h4;
   assign det_parity_error = go && sel == 3'h5;
endmodule // bws_agent
`default_nettype wire

// ---- verification/bws_props.sv ----
// checker of the bridge window and downstream status bank
`timescale 1ns/1ns
`default_nettype none
module bws_props
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // downstream events
   input wire logic parity_resp_en,
   input wire logic downstream_parity_error_n,
   input wire logic downstream_system_error_n,
   input wire logic sig_target_abort,
   input wire logic rcv_target_abort,
   input wire logic rcv_master_abort,
   input wire logic det_parity_error,
   // classifier
   input wire logic [63:0] check_addr,
   input wire logic io_hit,
   input wire logic mem_hit,
   input wire logic pf_hit
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // status word read; a write in between could clear, so flag checks demand none
   logic rd_st;
   assign rd_st = reg_rd && reg_addr == 8'h1C;
   a_io_caps: assert property (rd_st |=> reg_rdata[11:8] == 4'h1)
      else $error("io capability nibble wrong");
   a_status_fixed: assert property (
      rd_st |=> {reg_rdata[26:25], reg_rdata[23:21]} == 5'h09)
      else $error("fixed status bits wrong");
   a_mem_nibs: assert property (
      reg_rd && reg_addr == 8'h20 |=> reg_rdata[19:16] == 4'h0 && reg_rdata[3:0] == 4'h0)
      else $error("memory low nibbles not zero");
   a_pf_caps: assert property (
      reg_rd && reg_addr == 8'h24 |=> reg_rdata[19:16] == 4'h1 && reg_rdata[3:0] == 4'h1)
      else $error("prefetch capability nibbles wrong");
   a_perr_flag: assert property (
      !downstream_parity_error_n && parity_resp_en ##1 !reg_wr ##1 rd_st |=> reg_rdata[24])
      else $error("parity flag not set");
   a_sig_tabort: assert property (
      sig_target_abort ##1 !reg_wr ##1 rd_st |=> reg_rdata[27])
      else $error("signalled abort flag not set");
   a_rcv_tabort: assert property (
      rcv_target_abort ##1 !reg_wr ##1 rd_st |=> reg_rdata[28])
      else $error("received target abort flag not set");
   a_rcv_mabort: assert property (
      rcv_master_abort ##1 !reg_wr ##1 rd_st |=> reg_rdata[29])
      else $error("master abort flag not set");
   a_serr_flag: assert property (
      !downstream_system_error_n ##1 !reg_wr ##1 rd_st |=> reg_rdata[30])
      else $error("system error flag not set");
   a_det_perr: assert property (
      det_parity_error ##1 !reg_wr ##1 rd_st |=> reg_rdata[31])
      else $error("detected parity flag not set");
   a_set_wins: assert property (
      sig_target_abort && reg_wr && reg_addr == 8'h1C && reg_wdata[27]
      ##1 !reg_wr ##1 rd_st |=> reg_rdata[27])
      else $error("clear beat a new event");
   a_low_hits: assert property (io_hit || mem_hit |-> $past(check_addr[63:32]) == 32'h0)
      else $error("low window hit on a high address");
endmodule // bws_props
bind bws_top bws_props u_props (.*);
`default_nettype wire

// ---- verification/bws_top_bench.sv ----
// self-checking bench of the bridge window and status bank
`timescale 1ns/1ns
`default_nettype none
module bws_top_bench;
   // stimulus and observed signals
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic reg_wr = 1'h0, reg_rd = 1'h0, parity_resp_en = 1'h1, ev_go = 1'h0;
   logic [2:0] ev_sel = 3'h0;
   logic [63:0] check_addr = 64'h0;
   logic io_hit, mem_hit, pf_hit, downstream_parity_error_n, downstream_system_error_n;
   logic sig_target_abort, rcv_target_abort, rcv_master_abort, det_parity_error;
   int err_count = 0, check_count = 0;
   // rows: write, offset, data, expected read; reset rows first, 40 unmapped
   localparam logic [72:0] ROWS [13] = '{
      {1'h0,8'h1C,32'h0,32'h02200101}, {1'h0,8'h20,32'h0,32'h0},
      {1'h0,8'h24,32'h0,32'h00010001}, {1'h0,8'h28,32'h0,32'h0},
      {1'h0,8'h2C,32'h0,32'h0}, {1'h0,8'h30,32'h0,32'h0},
      {1'h1,8'h1C,32'hFFFFFFFF,32'h0220F1F1}, {1'h1,8'h20,32'hFFFFFFFF,32'hFFF0FFF0},
      {1'h1,8'h24,32'hFFFFFFFF,32'hFFF1FFF1}, {1'h1,8'h28,32'h12345678,32'h12345678},
      {1'h1,8'h2C,32'h9ABCDEF0,32'h9ABCDEF0}, {1'h1,8'h30,32'hFFFFFFFF,32'hFFFFFFFF},
      {1'h1,8'h40,32'hFFFFFFFF,32'h0}};
   // status bit of each agent command
   localparam int FBIT [6] = '{24, 30, 27, 28, 29, 31};
   // probes: address, expected io, mem, prefetch hits
   localparam logic [66:0] HITS [13] = '{
      {64'h12300000,3'h2}, {64'h122FFFFF,3'h0}, {64'h456FFFFF,3'h2}, {64'h45700000,3'h0},
      {64'h42000,3'h4}, {64'h41FFF,3'h0}, {64'h53FFF,3'h4}, {64'h54000,3'h0},
      {64'h170000000,3'h1}, {64'h1800FFFFF,3'h1}, {64'h180100000,3'h0},
      {64'h70000000,3'h0}, {64'h100042000,3'h0}};
   // clock of 8 ns
   always #4 clk = ~clk;
   bws_top dut (.*);
   bws_agent agent (.go(ev_go), .sel(ev_sel), .*);
   // compare and count
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // bus cycles, each entered and left at a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
      @(posedge clk);
   endtask
   // agent event, optionally with a clearing write in the same cycle
   task automatic fire(input int k, input logic w);
      ev_sel <= 3'(k);
      ev_go <= 1'h1;
      reg_addr <= 8'h1C;
      reg_wdata <= 32'h1 << FBIT[k];
      reg_wr <= w;
      @(posedge clk);
      ev_go <= 1'h0;
      reg_wr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rows(input int lo, input int hi);
      for (int i = lo; i < hi; i++)
      begin
         if (ROWS[i][72])
            wr(ROWS[i][71:64], ROWS[i][63:32]);
         rd(ROWS[i][71:64]);
         chk("register", d, ROWS[i][31:0]);
      end
   endtask
   // hits stand the cycle after the address
   task automatic probe(input logic [66:0] r);
      check_addr <= r[66:3];
      @(posedge clk);
      #1;
      chk("hits", 32'({io_hit, mem_hit, pf_hit}), 32'(r[2:0]));
      @(posedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      rows(0, 13);
      $display("test registers done");
      for (int k = 0; k < 6; k++)
      begin
         fire(k, 1'h0);
         rd(8'h1C);
         chk("flag set", d[FBIT[k]], 32'h1);
         wr(8'h1C, 32'h0);
         rd(8'h1C);
         chk("flag kept", d[FBIT[k]], 32'h1);
         wr(8'h1C, 32'h1 << FBIT[k]);
         rd(8'h1C);
         chk("flag cleared", d[FBIT[k]], 32'h0);
         fire(k, 1'h1);
         rd(8'h1C);
         chk("set beats clear", d[FBIT[k]], 32'h1);
         wr(8'h1C, 32'h1 << FBIT[k]);
      end
      parity_resp_en <= 1'h0;
      fire(0, 1'h0);
      rd(8'h1C);
      chk("parity gated", d[24], 32'h0);
      $display("test flags done");
      // windows: mem 123..456, prefetch 1_700..1_800, io 4_2..5_3
      wr(8'h20, 32'h45601230);
      wr(8'h24, 32'h80007000);
      wr(8'h28, 32'h1);
      wr(8'h2C, 32'h1);
      wr(8'h1C, 32'h3020);
      wr(8'h30, 32'h00050004);
      for (int i = 0; i < 13; i++)
         probe(HITS[i]);
      wr(8'h20, 32'h10002000);
      probe({64'h20000000, 3'h0});
      $display("test windows done");
      // second reset in mid-run, windows back to the lowest block
      nrst <= 1'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      rows(0, 6);
      probe({64'h0, 3'h7});
      $display("test second reset done");
      complete_run;
   end
endmodule // bws_top_bench
`default_nettype wire
